/* File: rtl/ubh_pkg.sv */
`default_nettype none

package ubh_pkg;

    // Link clock period; timing counts below derive from it
    localparam int LINK_PERIOD_NS = 32;
    // Least wait before driving the ready/strobe line after acknowledge
    localparam int T_ZIORDY_NS    = 20;
    // Least data setup before a strobe edge on data-in
    localparam int T_DVS_NS       = 20;
    localparam int ZIORDY_CYC     = (T_ZIORDY_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS;
    localparam int DVS_CYC        = (T_DVS_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS;
    localparam logic [3:0] ZIORDY_CNT = 4'(ZIORDY_CYC);
    localparam logic [3:0] DVS_CNT    = 4'(DVS_CYC);

    // Burst check word; polynomial and seed are plain defaults
    localparam int          DW        = 16;
    localparam logic [15:0] CRC_POLY  = 16'h1021;
    localparam logic [15:0] CRC_SEED  = 16'hffff;
    localparam logic [15:0] WORD_RST  = 16'h0000;

    // Pins as sampled in the link domain
    typedef struct packed {
        logic        dmack_n;
        logic        stop;
        logic        hline;
        logic [15:0] d;
    } ubh_pins_t;

    typedef enum logic [6:0] {
        ST_IDLE = 7'h01,
        ST_ACK  = 7'h02,
        ST_ZW   = 7'h04,
        ST_INIT = 7'h08,
        ST_IN   = 7'h10,
        ST_OUT  = 7'h20,
        ST_TERM = 7'h40
    } ubh_state_t;

    // One data word folded into the running check word
    function automatic logic [15:0] crc_next(input logic [15:0] c, input logic [15:0] d);
        logic [15:0] r;
        logic        fb;
        r = c;
        for (int i = 15; i >= 0; i--)
        begin
            fb = r[15] ^ d[i];
            r  = {r[14:0], 1'b0};
            if (fb)
            begin
                r = r ^ CRC_POLY;
            end
        end
        return r;
    endfunction

endpackage

`default_nettype wire

/* File: rtl/ubh_xfer.sv */
`timescale 1ns/1ps
`default_nettype none

// Toggle handshake carrying one word between clock domains
module ubh_xfer #(
    parameter int W = 16
) (
    input  wire logic         src_clk_i,
    input  wire logic         src_rst_i,
    input  wire logic         src_valid_i,
    input  wire logic [W-1:0] src_data_i,
    output logic              src_ready_o,
    input  wire logic         dst_clk_i,
    input  wire logic         dst_rst_i,
    input  wire logic         dst_take_i,
    output logic              dst_valid_o,
    output logic [W-1:0]      dst_data_o
);
    logic         req;
    logic         next_req;
    logic         next_ready;
    logic [W-1:0] hold;
    logic [W-1:0] next_hold;
    logic [1:0]   ack_s;
    logic [1:0]   req_s;
    logic         seen;
    logic         next_seen;
    logic         next_valid;
    logic [W-1:0] next_data;

    // Source: hold stays stable until the far side has copied it
    always_comb
    begin
        next_req   = req;
        next_ready = src_ready_o;
        next_hold  = hold;
        if (src_ready_o && src_valid_i)
        begin
            next_req   = ~req;
            next_ready = 1'b0;
            next_hold  = src_data_i;
        end
        else if (!src_ready_o && ack_s[1] == req)
        begin
            next_ready = 1'b1;
        end
    end

    always_ff @(posedge src_clk_i)
    begin
        if (src_rst_i)
        begin
            req         <= 1'b0;
            src_ready_o <= 1'b1;
            hold        <= '0;
            ack_s       <= 2'h0;
        end
        else
        begin
            req         <= next_req;
            src_ready_o <= next_ready;
            hold        <= next_hold;
            ack_s       <= {ack_s[0], seen};
        end
    end

    // Destination: copy on a new toggle, acknowledge at once
    always_comb
    begin
        next_seen  = seen;
        next_valid = dst_valid_o;
        next_data  = dst_data_o;
        if (dst_valid_o && dst_take_i)
        begin
            next_valid = 1'b0;
        end
        if (!dst_valid_o && req_s[1] != seen)
        begin
            next_valid = 1'b1;
            next_data  = hold;
            next_seen  = req_s[1];
        end
    end

    always_ff @(posedge dst_clk_i)
    begin
        if (dst_rst_i)
        begin
            seen        <= 1'b0;
            dst_valid_o <= 1'b0;
            dst_data_o  <= '0;
            req_s       <= 2'h0;
        end
        else
        begin
            seen        <= next_seen;
            dst_valid_o <= next_valid;
            dst_data_o  <= next_data;
            req_s       <= {req_s[0], req};
        end
    end

endmodule // ubh_xfer

`default_nettype wire

/* File: rtl/ubh_dev.sv */
`timescale 1ns/1ps
`default_nettype none

// Contract
// - Device stops data-in strobe edges soon after host ready negates.
// - Device drops DMARQ soon after STOP, no reassert this burst. In data-out the code ignores STOP before the first strobe fall.
// - Device raises a low strobe after STOP; that edge carries no data.
// - Device releases the data bus soon after dropping DMARQ.
// - Device captures the host check word as DMACK negates.
// - Device compares check words, reports first mismatch at command end.
// - Device releases its strobe line soon after DMACK negates.
// - Device requests data-out with DMARQ while DMACK is negated.
// - Device drives ready negated after a delay, until STOP drops.
// - Device asserts ready after STOP drops, holds it until first strobe fall.
module ubh_dev (
    input  wire logic        ref_clk_i,
    input  wire logic        sys_rst_i,
    input  wire logic        link_clk_i,
    input  wire logic        cmd_in_i,
    input  wire logic        cmd_out_i,
    input  wire logic        cmd_end_i,
    input  wire logic        tx_valid_i,
    input  wire logic [15:0] tx_data_i,
    output logic             tx_ready_o,
    output logic             rx_valid_o,
    output logic [15:0]      rx_data_o,
    output logic             crc_err_o,
    output logic             err_valid_o,
    input  wire logic        dmack_n_i,
    input  wire logic        stop_i,
    input  wire logic        hline_i,
    input  wire logic [15:0] d_i,
    output logic             dmarq_o,
    output logic             dline_o,
    output logic             dline_oe_o,
    output logic [15:0]      d_o,
    output logic             d_oe_o
);
    ubh_pkg::ubh_pins_t  pin_s1;
    ubh_pkg::ubh_pins_t  pin_s2;
    ubh_pkg::ubh_state_t st;
    ubh_pkg::ubh_state_t next_st;
    logic [1:0]  rst_s;
    logic        link_rst;
    logic [1:0]  cin_s;
    logic [1:0]  cout_s;
    logic        h_s3;
    logic        dir_out;
    logic        next_dir_out;
    logic [3:0]  cnt;
    logic [3:0]  next_cnt;
    logic        phase;
    logic        next_phase;
    logic        first_neg;
    logic        next_first_neg;
    logic [15:0] crc;
    logic [15:0] next_crc;
    logic        next_dmarq;
    logic        next_dline;
    logic        next_dline_oe;
    logic [15:0] next_d;
    logic        next_d_oe;
    logic        wv;
    logic        next_wv;
    logic [15:0] wd;
    logic [15:0] next_wd;
    logic        sv;
    logic        next_sv;
    logic        smis;
    logic        next_smis;
    logic        tx_ok;
    logic [15:0] tx_word;
    logic        tx_take;
    logic        st_valid;
    logic        st_mis;
    logic        err_pend;
    logic        next_err_pend;
    logic        next_crc_err;
    logic        h_edge;

    // Reset brought into the link domain; first stage feeds only the second
    always_ff @(posedge link_clk_i)
    begin
        rst_s <= {rst_s[0], sys_rst_i};
    end
    assign link_rst = rst_s[1];

    // Pin and command synchronisers; strobe and data sampled together
    always_ff @(posedge link_clk_i)
    begin
        if (link_rst)
        begin
            pin_s1 <= '{dmack_n: 1'b1, stop: 1'b0, hline: 1'b1, d: ubh_pkg::WORD_RST};
            pin_s2 <= '{dmack_n: 1'b1, stop: 1'b0, hline: 1'b1, d: ubh_pkg::WORD_RST};
            h_s3   <= 1'b1; // Idle levels: no false strobe edge after reset
            cin_s  <= 2'h0;
            cout_s <= 2'h0;
        end
        else
        begin
            pin_s1 <= {dmack_n_i, stop_i, hline_i, d_i};
            pin_s2 <= pin_s1;
            h_s3   <= pin_s2.hline;
            cin_s  <= {cin_s[0], cmd_in_i};
            cout_s <= {cout_s[0], cmd_out_i};
        end
    end

    // Host strobe transition, either direction
    assign h_edge = pin_s2.hline ^ h_s3;

    // Burst handshake; pins are two link cycles late, well inside the max times
    always_comb
    begin
        next_st        = st;
        next_dir_out   = dir_out;
        next_cnt       = cnt;
        next_phase     = phase;
        next_first_neg = first_neg;
        next_crc       = crc;
        next_dmarq     = dmarq_o;
        next_dline     = dline_o;
        next_dline_oe  = dline_oe_o;
        next_d         = d_o;
        next_d_oe      = d_oe_o;
        next_wv        = 1'b0;
        next_wd        = wd;
        next_sv        = 1'b0;
        next_smis      = smis;
        tx_take        = 1'b0;
        unique case (st)
            ubh_pkg::ST_IDLE:
            begin
                // Request only once the previous acknowledge is gone
                if (pin_s2.dmack_n && (cin_s[1] || cout_s[1]))
                begin
                    next_dmarq   = 1'b1;
                    next_dir_out = cout_s[1];
                    next_st      = ubh_pkg::ST_ACK;
                end
            end
            ubh_pkg::ST_ACK:
            begin
                if (!pin_s2.dmack_n)
                begin
                    next_cnt       = ubh_pkg::ZIORDY_CNT;
                    next_crc       = ubh_pkg::CRC_SEED;
                    next_first_neg = 1'b0;
                    next_phase     = 1'b0;
                    next_st        = ubh_pkg::ST_ZW;
                end
            end
            ubh_pkg::ST_ZW:
            begin
                if (cnt > 4'h1)
                begin
                    next_cnt = cnt - 4'h1;
                end
                else
                begin
                    // Line starts high: strobe idle or ready negated
                    next_dline_oe = 1'b1;
                    next_dline    = 1'b1;
                    next_st       = ubh_pkg::ST_INIT;
                end
            end
            ubh_pkg::ST_INIT:
            begin
                if (dir_out && !pin_s2.stop)
                begin
                    next_dline = 1'b0;
                    next_st    = ubh_pkg::ST_OUT;
                end
                else if (!dir_out && !pin_s2.stop && !pin_s2.hline)
                begin
                    next_d_oe = 1'b1;
                    next_st   = ubh_pkg::ST_IN;
                end
            end
            ubh_pkg::ST_IN:
            begin
                if (phase)
                begin
                    // A word already on the bus is always strobed out
                    if (cnt > 4'h1)
                    begin
                        next_cnt = cnt - 4'h1;
                    end
                    else
                    begin
                        next_dline = ~dline_o;
                        next_phase = 1'b0;
                    end
                end
                else if (pin_s2.stop)
                begin
                    next_dmarq = 1'b0;
                    next_dline = 1'b1;
                    next_d_oe  = 1'b0;
                    next_st    = ubh_pkg::ST_TERM;
                end
                else if (!pin_s2.hline && tx_ok)
                begin
                    tx_take    = 1'b1;
                    next_d     = tx_word;
                    next_crc   = ubh_pkg::crc_next(crc, tx_word);
                    next_cnt   = ubh_pkg::DVS_CNT;
                    next_phase = 1'b1;
                end
            end
            ubh_pkg::ST_OUT:
            begin
                if (h_edge)
                begin
                    next_wv  = 1'b1;
                    next_wd  = pin_s2.d;
                    next_crc = ubh_pkg::crc_next(crc, pin_s2.d);
                    if (!pin_s2.hline)
                    begin
                        next_first_neg = 1'b1;
                    end
                end
                // STOP before the first strobe fall is not a termination
                if (pin_s2.stop && (first_neg || (h_edge && !pin_s2.hline)))
                begin
                    next_dmarq = 1'b0;
                    next_dline = 1'b1;
                    next_st    = ubh_pkg::ST_TERM;
                end
            end
            ubh_pkg::ST_TERM:
            begin
                // Data and acknowledge share a sampling stage
                if (pin_s2.dmack_n)
                begin
                    next_sv       = 1'b1;
                    next_smis     = (pin_s2.d != crc);
                    next_dline_oe = 1'b0;
                    next_d_oe     = 1'b0;
                    next_st       = ubh_pkg::ST_IDLE;
                end
            end
            default:
            begin
                next_st = ubh_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge link_clk_i)
    begin
        if (link_rst)
        begin
            st         <= ubh_pkg::ST_IDLE;
            dir_out    <= 1'b0;
            cnt        <= 4'h0;
            phase      <= 1'b0;
            first_neg  <= 1'b0;
            crc        <= ubh_pkg::CRC_SEED;
            dmarq_o    <= 1'b0;
            dline_o    <= 1'b1;
            dline_oe_o <= 1'b0;
            d_o        <= ubh_pkg::WORD_RST;
            d_oe_o     <= 1'b0;
            wv         <= 1'b0;
            wd         <= ubh_pkg::WORD_RST;
            sv         <= 1'b0;
            smis       <= 1'b0;
        end
        else
        begin
            st         <= next_st;
            dir_out    <= next_dir_out;
            cnt        <= next_cnt;
            phase      <= next_phase;
            first_neg  <= next_first_neg;
            crc        <= next_crc;
            dmarq_o    <= next_dmarq;
            dline_o    <= next_dline;
            dline_oe_o <= next_dline_oe;
            d_o        <= next_d;
            d_oe_o     <= next_d_oe;
            wv         <= next_wv;
            wd         <= next_wd;
            sv         <= next_sv;
            smis       <= next_smis;
        end
    end

    // Words to send, system to link
    ubh_xfer #(.W(16)) u_tx (
        .src_clk_i   (ref_clk_i),
        .src_rst_i   (sys_rst_i),
        .src_valid_i (tx_valid_i),
        .src_data_i  (tx_data_i),
        .src_ready_o (tx_ready_o),
        .dst_clk_i   (link_clk_i),
        .dst_rst_i   (link_rst),
        .dst_take_i  (tx_take),
        .dst_valid_o (tx_ok),
        .dst_data_o  (tx_word)
    );

    // Received words; no buffer, so host strobes must allow the round trip
    ubh_xfer #(.W(16)) u_rx (
        .src_clk_i   (link_clk_i),
        .src_rst_i   (link_rst),
        .src_valid_i (wv),
        .src_data_i  (wd),
        .src_ready_o (),
        .dst_clk_i   (ref_clk_i),
        .dst_rst_i   (sys_rst_i),
        .dst_take_i  (1'b1),
        .dst_valid_o (rx_valid_o),
        .dst_data_o  (rx_data_o)
    );

    // Per-burst check result
    ubh_xfer #(.W(1)) u_st (
        .src_clk_i   (link_clk_i),
        .src_rst_i   (link_rst),
        .src_valid_i (sv),
        .src_data_i  (smis),
        .src_ready_o (),
        .dst_clk_i   (ref_clk_i),
        .dst_rst_i   (sys_rst_i),
        .dst_take_i  (1'b1),
        .dst_valid_o (st_valid),
        .dst_data_o  (st_mis)
    );

    // Mismatch held until command end; a new one beats the clear
    always_comb
    begin
        next_err_pend = err_pend;
        next_crc_err  = crc_err_o;
        if (cmd_end_i)
        begin
            next_crc_err  = err_pend;
            next_err_pend = 1'b0;
        end
        if (st_valid && st_mis)
        begin
            next_err_pend = 1'b1;
        end
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (sys_rst_i)
        begin
            err_pend    <= 1'b0;
            crc_err_o   <= 1'b0;
            err_valid_o <= 1'b0;
        end
        else
        begin
            err_pend    <= next_err_pend;
            crc_err_o   <= next_crc_err;
            err_valid_o <= cmd_end_i;
        end
    end

endmodule // ubh_dev

`default_nettype wire

/* File: testbench/ubh_dev_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
// Pin watcher; bounds allow for the two-flop pin sync plus one register
module ubh_dev_monitor (
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    input wire logic link_clk_i,
    input wire logic cmd_end_i,
    input wire logic err_valid_o,
    input wire logic dmack_n_i,
    input wire logic stop_i,
    input wire logic hline_i,
    input wire logic dmarq_o,
    input wire logic dline_o,
    input wire logic dline_oe_o,
    input wire logic d_oe_o
);
    property p_rq_drop;
        @(posedge link_clk_i) disable iff (sys_rst_i)
        $rose(stop_i) && !dmack_n_i |-> ##[1:5] !dmarq_o;
    endproperty
    a_rq_drop: assert property (p_rq_drop) else $error("request held after stop");
    property p_rq_hold;
        @(posedge link_clk_i) disable iff (sys_rst_i)
        $rose(dmarq_o) |-> dmack_n_i && $past(dmack_n_i, 3);
    endproperty
    a_rq_hold: assert property (p_rq_hold) else $error("request raised inside a burst");
    property p_edge_up;
        @(posedge link_clk_i) disable iff (sys_rst_i)
        $rose(stop_i) && !dmack_n_i && dline_oe_o |-> ##[1:5] dline_o;
    endproperty
    a_edge_up: assert property (p_edge_up) else $error("device line not raised after stop");
    property p_bus_off;
        @(posedge link_clk_i) disable iff (sys_rst_i) $fell(dmarq_o) |-> ##[0:1] !d_oe_o;
    endproperty
    a_bus_off: assert property (p_bus_off) else $error("data bus still driven");
    property p_edge_off;
        @(posedge link_clk_i) disable iff (sys_rst_i) $rose(dmack_n_i) |-> ##[1:5] !dline_oe_o;
    endproperty
    a_edge_off: assert property (p_edge_off) else $error("device line not released");
    property p_oe_hold;
        @(posedge link_clk_i) disable iff (sys_rst_i) dline_oe_o && !dmack_n_i |=> dline_oe_o;
    endproperty
    a_oe_hold: assert property (p_oe_hold) else $error("device line released early");
    property p_oe_start;
        @(posedge link_clk_i) disable iff (sys_rst_i)
        $rose(dline_oe_o) |-> !dmack_n_i && !$past(dmack_n_i, 2);
    endproperty
    a_oe_start: assert property (p_oe_start) else $error("device line driven too soon");
    property p_ready_on;
        @(posedge link_clk_i) disable iff (sys_rst_i)
        $fell(stop_i) && !dmack_n_i && hline_i |-> ##[1:5] !dline_o;
    endproperty
    a_ready_on: assert property (p_ready_on) else $error("ready not asserted");
    property p_quiet;
        @(posedge link_clk_i) disable iff (sys_rst_i)
        (hline_i && d_oe_o) [*6] |-> $stable(dline_o);
    endproperty
    a_quiet: assert property (p_quiet) else $error("strobe edge while host not ready");
    property p_report;
        @(posedge ref_clk_i) disable iff (sys_rst_i) cmd_end_i |=> err_valid_o ##1 !err_valid_o;
    endproperty
    a_report: assert property (p_report) else $error("no result after command end");
    c_rq_drop: cover property (@(posedge link_clk_i) $fell(dmarq_o));
    c_oe_on: cover property (@(posedge link_clk_i) $rose(dline_oe_o));
    c_report: cover property (@(posedge ref_clk_i) cmd_end_i ##1 err_valid_o);
endmodule // ubh_dev_monitor

bind ubh_dev ubh_dev_monitor mon (.ref_clk_i, .sys_rst_i, .link_clk_i, .cmd_end_i,
    .err_valid_o, .dmack_n_i, .stop_i, .hline_i, .dmarq_o, .dline_o, .dline_oe_o, .d_oe_o);
`default_nettype wire

/* File: testbench/ubh_host.sv */
`timescale 1ns/1ps
`default_nettype none
// Behavioural host controller on the far side of the device pins
module ubh_host (
    input  wire logic        clk_i,
    input  wire logic        dmarq_i,
    input  wire logic        dline_i,
    input  wire logic        d_oe_i,
    input  wire logic [15:0] dev_d_i,
    output logic             dmack_n_o,
    output logic             stop_o,
    output logic             hline_o,
    output logic [15:0]      d_o
);
    logic [15:0] rxq[$];
    int          fails = 0;
    initial
    begin
        dmack_n_o = 1'b1;
        stop_o = 1'b0;
        hline_o = 1'b1;
        d_o = 16'h5a5a;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    // Own check word fold, kept apart from the device's
    function automatic logic [15:0] fold(input logic [15:0] c, input logic [15:0] w);
        logic [15:0] r;
        r = c;
        for (int i = 15; i >= 0; i--)
            r = (r[15] ^ w[i]) ? ({r[14:0], 1'b0} ^ ubh_pkg::CRC_POLY) : {r[14:0], 1'b0};
        return r;
    endfunction
    // Stop and host line settle well before acknowledge
    task automatic open_burst();
        int k;
        for (k = 0; k < 300 && dmarq_i !== 1'b1; k++) tick(1);
        if (dmarq_i !== 1'b1) fails++;
        stop_o <= 1'b1;
        hline_o <= 1'b1;
        tick(3);
        dmack_n_o <= 1'b0;
        tick(4);
    endtask
    // Check word goes out only after the request drops
    task automatic close_burst(input logic [15:0] c);
        int k;
        stop_o <= 1'b1;
        for (k = 0; k < 50 && dmarq_i !== 1'b0; k++) tick(1);
        if (dmarq_i !== 1'b0) fails++;
        hline_o <= 1'b1;
        tick(2);
        d_o <= c;
        tick(3);
        dmack_n_o <= 1'b1;
        tick(3);
        d_o <= ~c; // Released bus shows the inverse, not the last value
        tick(4);
        stop_o <= 1'b0;
    endtask
    task automatic out_burst(input int n, input logic [15:0] base, input bit bad);
        logic [15:0] c;
        int          k;
        c = ubh_pkg::CRC_SEED;
        open_burst();
        stop_o <= 1'b0;
        for (k = 0; k < 50 && dline_i !== 1'b0; k++) tick(1);
        if (dline_i !== 1'b0) fails++;
        tick(2);
        for (k = 0; k < n; k++)
        begin
            d_o <= base + 16'(k);
            c = fold(c, base + 16'(k));
            tick(2);
            hline_o <= ~hline_o;
            tick(8); // Slow spacing: the device keeps no buffer
        end
        close_burst(bad ? ~c : c);
    endtask
    task automatic in_burst(input int n);
        logic [15:0] c;
        logic        last;
        int          k;
        c = ubh_pkg::CRC_SEED;
        rxq.delete();
        open_burst();
        stop_o <= 1'b0;
        hline_o <= 1'b0;
        last = 1'b1;
        for (k = 0; k < 400 && rxq.size() < n; k++)
        begin
            tick(1);
            if (d_oe_i === 1'b1 && dline_i !== last)
            begin
                rxq.push_back(dev_d_i);
                c = fold(c, dev_d_i);
            end
            last = dline_i;
        end
        if (rxq.size() < n) fails++;
        hline_o <= 1'b1;
        // Late words may still arrive before STOP; take and fold them
        for (k = 0; k < 5; k++)
        begin
            tick(1);
            if (d_oe_i === 1'b1 && dline_i !== last)
            begin
                rxq.push_back(dev_d_i);
                c = fold(c, dev_d_i);
            end
            last = dline_i;
        end
        close_burst(c);
    endtask
endmodule // ubh_host
`default_nettype wire

/* File: testbench/ultra_dma_burst_handshake_test.sv */
`timescale 1ns/1ps
`default_nettype none
// Data-out, data-in and check word scenarios against the host model
module ultra_dma_burst_handshake_test;
    logic        ref_clk_i, link_clk_i, sys_rst_i, cmd_in_i, cmd_out_i, cmd_end_i;
    logic        tx_valid_i, tx_ready_o, rx_valid_o, crc_err_o, err_valid_o;
    logic        dmack_n_i, stop_i, hline_i, dmarq_o, dline_o, dline_oe_o, d_oe_o;
    logic [15:0] tx_data_i, rx_data_o, d_i, d_o, host_d;
    logic [15:0] rx_seen[$];
    int          bad_count, check_count;
    ubh_dev dut (.ref_clk_i, .sys_rst_i, .link_clk_i, .cmd_in_i, .cmd_out_i, .cmd_end_i,
        .tx_valid_i, .tx_data_i, .tx_ready_o, .rx_valid_o, .rx_data_o, .crc_err_o, .err_valid_o,
        .dmack_n_i, .stop_i, .hline_i, .d_i, .dmarq_o, .dline_o, .dline_oe_o, .d_o, .d_oe_o);
    ubh_host host (.clk_i(link_clk_i), .dmarq_i(dmarq_o), .dline_i(dline_o), .d_oe_i(d_oe_o),
        .dev_d_i(d_o), .dmack_n_o(dmack_n_i), .stop_o(stop_i), .hline_o(hline_i), .d_o(host_d));
    // Bus level: the device when it drives, the host otherwise
    assign d_i = d_oe_o ? d_o : host_d;
    initial
    begin
        ref_clk_i = 1'b0;
        forever #5 ref_clk_i = ~ref_clk_i;
    end
    // Odd offset keeps link edges off the system edges
    initial
    begin
        link_clk_i = 1'b0;
        #3.3;
        forever #16 link_clk_i = ~link_clk_i;
    end
    always @(posedge ref_clk_i) if (rx_valid_o === 1'b1) rx_seen.push_back(rx_data_o);
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        check_count++;
        if (got !== exp)
        begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // Command level is dropped once the request shows
    task automatic wait_rq();
        int k;
        for (k = 0; k < 100 && dmarq_o !== 1'b1; k++) @(posedge ref_clk_i);
        if (dmarq_o !== 1'b1)
        begin
            bad_count++;
            results();
        end
        cmd_in_i <= 1'b0;
        cmd_out_i <= 1'b0;
    endtask
    task automatic end_cmd(input logic err);
        repeat (10) @(posedge ref_clk_i);
        cmd_end_i <= 1'b1;
        @(posedge ref_clk_i);
        cmd_end_i <= 1'b0;
        @(posedge ref_clk_i);
        check("err_valid", 16'h0001, {15'h0000, err_valid_o});
        check("crc_err", {15'h0000, err}, {15'h0000, crc_err_o});
        $display("command end done");
    endtask
    task automatic t_out(input int n, input logic [15:0] base, input bit bad);
        rx_seen.delete();
        cmd_out_i <= 1'b1;
        wait_rq();
        host.out_burst(n, base, bad);
        repeat (10) @(posedge ref_clk_i);
        check("host faults", 16'h0000, 16'(host.fails));
        check("out count", 16'(n), 16'(rx_seen.size()));
        for (int k = 0; k < n; k++) check("out word", base + 16'(k), rx_seen[k]);
        $display("data-out burst done");
    endtask
    task automatic t_in(input int n, input logic [15:0] base);
        int j;
        cmd_in_i <= 1'b1;
        wait_rq();
        fork
            host.in_burst(n);
            begin
                for (int k = 0; k < n; k++)
                begin
                    tx_valid_i <= 1'b1;
                    tx_data_i <= base + 16'(k);
                    @(posedge ref_clk_i);
                    for (j = 0; j < 900 && tx_ready_o !== 1'b1; j++) @(posedge ref_clk_i);
                    if (j == 900) bad_count++;
                end
                // Drop at the take edge, else the last word is offered twice
                tx_valid_i <= 1'b0;
            end
        join
        check("host faults", 16'h0000, 16'(host.fails));
        check("in count", 16'(n), 16'(host.rxq.size()));
        for (int k = 0; k < n; k++) check("in word", base + 16'(k), host.rxq[k]);
        $display("data-in burst done");
    endtask
    initial
    begin
        sys_rst_i = 1'b1;
        {cmd_in_i, cmd_out_i, cmd_end_i, tx_valid_i} = 4'h0;
        tx_data_i = 16'h0000;
        bad_count = 0;
        check_count = 0;
        // Link side sees reset late, so it spans four link edges
        repeat (4) @(posedge link_clk_i);
        @(posedge ref_clk_i);
        sys_rst_i <= 1'b0;
        @(posedge ref_clk_i);
        check("dmarq", 16'h0000, {15'h0000, dmarq_o});
        check("dline_oe", 16'h0000, {15'h0000, dline_oe_o});
        check("tx_ready", 16'h0001, {15'h0000, tx_ready_o});
        $display("reset values done");
        repeat (20) @(posedge ref_clk_i);
        t_out(1, 16'hbeef, 1'b1);
        t_out(4, 16'h1230, 1'b0);
        end_cmd(1'b1);
        t_out(5, 16'h0a00, 1'b0);
        end_cmd(1'b0);
        t_in(3, 16'hc001);
        end_cmd(1'b0);
        results();
    end
endmodule // ultra_dma_burst_handshake_test
`default_nettype wire
